// [byte_fifo.sv]
// Synchronous FIFO with valid and ready on both sides.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap for free.
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("byte_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
  logic [AW-1:0]    wr_ptr_reg;   // Next slot to write.
  logic [AW-1:0]    rd_ptr_reg;   // Oldest stored slot.
  logic [AW:0]      count_reg;    // Words held.
  logic             push;
  logic             pop;

  // Full and empty come straight from the word count.
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write; memory needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // byte_fifo

// [framer_pkg.sv]
// Shared constants, record types and tables for the sentence framer.
package framer_pkg;

  // Clock period and the millisecond unit of the time stamp.
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1_000_000;
  // Cycles per millisecond, rounded down (exact at 25 MHz).
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Widths of the binary quantities that feed the sentences.
  localparam int MAG_W   = 44;  // Holds any 13-digit magnitude.
  localparam int ANGLE_W = 25;  // Signed hundredths of a degree.
  localparam int AXIS_W  = 38;  // Signed scaled axis value.
  localparam int UTC_W   = 17;  // Seconds of the UTC day.

  // Milliseconds in one day, where the UTC time stamp wraps.
  localparam logic [MAG_W-1:0] DAY_MS = 44'h000_0526_5C00;
  // Milliseconds per second, used to load the UTC time.
  localparam logic [MAG_W-1:0] SEC_MS = 44'h000_0000_03E8;

  // Digit counts and fractional digit counts of each field kind.
  localparam int TIME_DIGITS  = 13;
  localparam int TIME_FRAC    = 3;
  localparam int ANGLE_DIGITS = 7;
  localparam int ANGLE_FRAC   = 2;
  localparam int AXIS_DIGITS  = 11;
  localparam int FINE_FRAC    = 4;  // Accelerometer and magnetometer.
  localparam int GYRO_FRAC    = 2;
  localparam int SEL_DIGITS   = 1;

  // Sentence geometry.
  localparam int HDR_LEN    = 6;  // Dollar sign plus five letters.
  localparam int ATT_FIELDS = 5;
  localparam int SNS_FIELDS = 5;

  // Sensor selector codes carried in the first sensor field.
  localparam logic [1:0] SEL_GYRO  = 2'h0;
  localparam logic [1:0] SEL_ACCEL = 2'h1;
  localparam logic [1:0] SEL_MAG   = 2'h2;

  // Header tokens, byte by byte, as they go on the wire.
  localparam logic [7:0] ATT_HDR [HDR_LEN] =
    '{8'h24, 8'h50, 8'h43, 8'h48, 8'h52, 8'h41};
  localparam logic [7:0] SNS_HDR [HDR_LEN] =
    '{8'h24, 8'h50, 8'h43, 8'h48, 8'h52, 8'h53};

  // Character codes used by the framer.
  localparam logic [7:0] CHR_COMMA = 8'h2C;
  localparam logic [7:0] CHR_STAR  = 8'h2A;
  localparam logic [7:0] CHR_MINUS = 8'h2D;
  localparam logic [7:0] CHR_POINT = 8'h2E;
  localparam logic [7:0] CHR_ZERO  = 8'h30;
  localparam logic [7:0] CHR_A     = 8'h41;
  localparam logic [7:0] CHR_CR    = 8'h0D;
  localparam logic [7:0] CHR_LF    = 8'h0A;

  // Depth of the output byte FIFO.
  localparam int OUT_DEPTH = 16;

  // Attitude estimate in hundredths of a degree.
  typedef struct packed {
    logic signed [ANGLE_W-1:0] roll;
    logic signed [ANGLE_W-1:0] pitch;
    logic signed [ANGLE_W-1:0] yaw;
  } attitude_type;

  // One three-axis sample.
  typedef struct packed {
    logic signed [AXIS_W-1:0] x;
    logic signed [AXIS_W-1:0] y;
    logic signed [AXIS_W-1:0] z;
  } axis_triple_type;

  // Raw data of the three sensors for one update.
  typedef struct packed {
    axis_triple_type gyro;   // Hundredths of a degree per second.
    axis_triple_type accel;  // Ten-thousandths of a gravity.
    axis_triple_type mag;    // Ten-thousandths of the unit norm.
  } raw_sensor_type;

  typedef logic [MAG_W-1:0] pow_table_type [TIME_DIGITS];

  // Powers of ten from one up to ten to the twelfth.
  function automatic pow_table_type pow10_table();
    pow_table_type t;
    t[0] = MAG_W'(1);
    for (int i = 1; i < TIME_DIGITS; i++) begin
      t[i] = MAG_W'(t[i-1] * MAG_W'(10));
    end
    return t;
  endfunction

  localparam pow_table_type POW10 = pow10_table();

endpackage

// [host_sink.sv]
// Host model that takes framer bytes, with optional stalls.
module host_sink (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Stall controls from the bench.
  input  wire logic       hold,
  input  wire logic       slow,
  // Byte stream from the framer.
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];  // Bytes taken, parsed later by the bench.
  // Ready drops while held and on every other cycle when slow.
  always @(posedge clk or posedge rst) begin
    if (rst) out_ready <= 1'b0;
    else out_ready <= !hold && (!slow || !out_ready);
  end
  // Every taken byte is kept so the checksum can be recomputed.
  always @(posedge clk) begin
    if (!rst && out_valid && out_ready) rx_q.push_back(out_data);
  end
endmodule // host_sink

// [sentence_framer.sv]
// Builds attitude and raw sensor ASCII sentences onto a byte stream.
// What this block does
// - Attitude: header, time, roll, pitch, yaw, heading, checksum.
// - Every sentence opens with its header token.
// - Time: up to 13 digits, three decimals.
// - Time counts uptime, or UTC with GPS pulse.
// - Angles: degrees, up to 7 digits, two decimals.
// - Heading from GPS; other angles from estimate.
// - Checksum XORs the bytes between dollar and asterisk.
// - Checksum written as hex after an asterisk.
// - Sensor: header, selector, time, X, Y, Z, checksum.
// - Sensor sentence sent three times per update.
// - Selector 0 gyro, 1 accelerometer, 2 magnetometer.
// - Axis: up to 11 digits; decimals 4, gyro 2.
// - Axis units: deg/s, gravities, unit-norm vector.
module sentence_framer
  import framer_pkg::*;
#(
  parameter int MS_DIV    = framer_pkg::MS_CYCLES,
  parameter int FIFO_DEPTH = framer_pkg::OUT_DEPTH
) (
  // Clock and reset.
  input  wire logic                             clk,
  input  wire logic                             rst,
  // Attitude update request.
  input  wire logic                             att_valid,
  output logic                                  att_ready,
  input  wire framer_pkg::attitude_type         att_data,
  input  wire logic signed [framer_pkg::ANGLE_W-1:0] gps_heading,
  // Raw sensor update request.
  input  wire logic                             sns_valid,
  output logic                                  sns_ready,
  input  wire framer_pkg::raw_sensor_type       sns_data,
  // GPS time reference.
  input  wire logic                             gps_present,
  input  wire logic                             gps_second_pulse,
  input  wire logic [framer_pkg::UTC_W-1:0]     gps_utc_second,
  // Serial byte stream toward the transmitter.
  output logic                                  out_valid,
  input  wire logic                             out_ready,
  output logic [7:0]                            out_data
);

  import framer_pkg::*;

  // The millisecond divider needs at least one cycle per tick.
  initial begin
    if (MS_DIV < 1 || FIFO_DEPTH < 2) begin
      $error("sentence_framer: MS_DIV and FIFO_DEPTH out of range");
    end
  end

  // Sequencer states: idle, divide, and one per kind of byte sent.
  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_COMMA, S_SIGN, S_DIV, S_DIGIT, S_POINT,
    S_STAR, S_CKH, S_CKL, S_CR, S_LF
  } state_type;

  state_type              state_reg;      // Current sequencer state.
  logic [31:0]            ms_div_reg;     // Cycle count within a ms.
  logic [MAG_W-1:0]       time_ms_reg;    // Running time stamp in ms.
  logic                   is_sns_reg;     // Sentence kind in flight.
  logic [1:0]             inst_reg;       // Sensor instance in flight.
  attitude_type           att_reg;        // Latched attitude.
  logic signed [ANGLE_W-1:0] head_reg;    // Latched GPS heading.
  raw_sensor_type         sns_reg;        // Latched sensor data.
  logic [MAG_W-1:0]       stamp_reg;      // Time stamp of the update.
  logic [2:0]             hdr_idx_reg;    // Header byte index.
  logic [2:0]             fld_reg;        // Field index.
  logic [MAG_W-1:0]       mag_reg;        // Magnitude still to print.
  logic [3:0]             pos_reg;        // Digit position printed.
  logic [3:0]             dig_reg;        // Digit being counted.
  logic [3:0]             frac_reg;       // Decimals of the field.
  logic                   started_reg;    // A digit has been shown.
  logic [7:0]             ck_reg;         // Running XOR checksum.

  // Field selected by the sequencer and its format.
  logic signed [MAG_W:0]  fld_value;
  logic [3:0]             fld_digits;
  logic [3:0]             fld_frac;
  logic [MAG_W-1:0]       fld_abs;
  logic [MAG_W-1:0]       fld_limit;
  axis_triple_type        cur_axis;

  // Byte offered to the FIFO in this cycle.
  logic                   push_valid;
  logic [7:0]             push_byte;
  logic                   push_ready;
  logic                   push_ck;        // Byte enters the checksum.
  logic                   fire;
  logic                   show_digit;
  logic                   last_field;
  logic                   start_att;
  logic                   start_sns;
  logic                   ms_tick;

  assign ms_tick = (ms_div_reg == 32'(MS_DIV - 1));

  // Millisecond divider, reloaded by the GPS second pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_div_reg <= '0;
    end else if (gps_present && gps_second_pulse) begin
      ms_div_reg <= '0;
    end else if (ms_tick) begin
      ms_div_reg <= '0;
    end else begin
      ms_div_reg <= ms_div_reg + 1'b1;
    end
  end

  // Time stamp: uptime without GPS, UTC time of day with it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      time_ms_reg <= '0;
    end else if (gps_present && gps_second_pulse) begin
      time_ms_reg <= MAG_W'(MAG_W'(gps_utc_second) * SEC_MS);
    end else if (ms_tick) begin
      if (gps_present && time_ms_reg + 1'b1 >= DAY_MS) begin
        time_ms_reg <= '0;
      end else begin
        time_ms_reg <= time_ms_reg + 1'b1;
      end
    end
  end

  // Requests are taken only while idle; attitude goes first.
  assign start_att = (state_reg == S_IDLE) && att_valid;
  assign start_sns = (state_reg == S_IDLE) && !att_valid && sns_valid;
  assign att_ready = start_att;
  assign sns_ready = start_sns;

  // Latch the update and its time stamp when a request is taken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      att_reg    <= '0;
      head_reg   <= '0;
      sns_reg    <= '0;
      stamp_reg  <= '0;
      is_sns_reg <= 1'b0;
    end else if (start_att) begin
      att_reg    <= att_data;
      head_reg   <= gps_heading;
      stamp_reg  <= time_ms_reg;
      is_sns_reg <= 1'b0;
    end else if (start_sns) begin
      sns_reg    <= sns_data;
      stamp_reg  <= time_ms_reg;
      is_sns_reg <= 1'b1;
    end
  end

  // Pick the axis group for the current sensor instance.
  always_comb begin
    unique case (inst_reg)
      SEL_GYRO:  cur_axis = sns_reg.gyro;
      SEL_ACCEL: cur_axis = sns_reg.accel;
      default:   cur_axis = sns_reg.mag;
    endcase
  end

  // Field value and format for the current field of the sentence.
  always_comb begin
    fld_value  = '0;
    fld_digits = 4'(ANGLE_DIGITS);
    fld_frac   = 4'(ANGLE_FRAC);
    if (!is_sns_reg) begin
      unique case (fld_reg)
        3'h0: begin
          fld_value  = (MAG_W+1)'(stamp_reg);
          fld_digits = 4'(TIME_DIGITS);
          fld_frac   = 4'(TIME_FRAC);
        end
        3'h1: fld_value = (MAG_W+1)'(att_reg.roll);
        3'h2: fld_value = (MAG_W+1)'(att_reg.pitch);
        3'h3: fld_value = (MAG_W+1)'(att_reg.yaw);
        default: fld_value = (MAG_W+1)'(head_reg);
      endcase
    end else begin
      fld_digits = 4'(AXIS_DIGITS);
      fld_frac   = (inst_reg == SEL_GYRO) ? 4'(GYRO_FRAC)
                                          : 4'(FINE_FRAC);
      unique case (fld_reg)
        3'h0: begin
          fld_value  = (MAG_W+1)'(inst_reg);
          fld_digits = 4'(SEL_DIGITS);
          fld_frac   = 4'h0;
        end
        3'h1: begin
          fld_value  = (MAG_W+1)'(stamp_reg);
          fld_digits = 4'(TIME_DIGITS);
          fld_frac   = 4'(TIME_FRAC);
        end
        3'h2: fld_value = (MAG_W+1)'(cur_axis.x);
        3'h3: fld_value = (MAG_W+1)'(cur_axis.y);
        default: fld_value = (MAG_W+1)'(cur_axis.z);
      endcase
    end
  end

  // Magnitude, clamped to the largest value the field can show.
  always_comb begin
    fld_abs   = fld_value[MAG_W] ? MAG_W'(-fld_value) : fld_value[MAG_W-1:0];
    // Largest value the field shows: ten to the digit count, less one.
    fld_limit = MAG_W'(POW10[fld_digits - 4'h1] * MAG_W'(10)) - 1'b1;
    if (fld_abs > fld_limit) begin
      fld_abs = fld_limit;
    end
  end

  assign last_field = is_sns_reg ? (fld_reg == 3'(SNS_FIELDS))
                                 : (fld_reg == 3'(ATT_FIELDS));
  // Leading zeros are dropped down to the units digit.
  assign show_digit = started_reg || (dig_reg != 4'h0) ||
                      (pos_reg <= frac_reg);

  // Byte offered in each state; the dollar sign stays out of the XOR.
  always_comb begin
    push_valid = 1'b1;
    push_ck    = 1'b1;
    push_byte  = CHR_COMMA;
    unique case (state_reg)
      S_IDLE, S_DIV: begin
        push_valid = 1'b0;
      end
      S_HDR: begin
        push_byte = is_sns_reg ? SNS_HDR[hdr_idx_reg]
                               : ATT_HDR[hdr_idx_reg];
        push_ck   = (hdr_idx_reg != 3'h0);
      end
      S_COMMA: push_byte = CHR_COMMA;
      S_SIGN:  push_byte = CHR_MINUS;
      S_DIGIT: begin
        push_valid = show_digit;
        push_byte  = CHR_ZERO + 8'(dig_reg);
      end
      S_POINT: push_byte = CHR_POINT;
      S_STAR: begin
        push_byte = CHR_STAR;
        push_ck   = 1'b0;
      end
      S_CKH: begin
        push_byte = (ck_reg[7:4] < 4'hA) ? CHR_ZERO + 8'(ck_reg[7:4])
                  : CHR_A + 8'(ck_reg[7:4] - 4'hA);
        push_ck   = 1'b0;
      end
      S_CKL: begin
        push_byte = (ck_reg[3:0] < 4'hA) ? CHR_ZERO + 8'(ck_reg[3:0])
                  : CHR_A + 8'(ck_reg[3:0] - 4'hA);
        push_ck   = 1'b0;
      end
      S_CR: begin
        push_byte = CHR_CR;
        push_ck   = 1'b0;
      end
      S_LF: begin
        push_byte = CHR_LF;
        push_ck   = 1'b0;
      end
      default: push_valid = 1'b0;
    endcase
  end

  // A state that emits waits for FIFO room; others always move on.
  assign fire = !push_valid || push_ready;

  // Running checksum, cleared at each header start.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_reg <= '0;
    end else if (state_reg == S_HDR && hdr_idx_reg == 3'h0) begin
      ck_reg <= '0;
    end else if (push_valid && push_ready && push_ck) begin
      ck_reg <= ck_reg ^ push_byte;
    end
  end

  // Sentence sequencer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= S_IDLE;
      inst_reg    <= '0;
      hdr_idx_reg <= '0;
      fld_reg     <= '0;
      mag_reg     <= '0;
      pos_reg     <= '0;
      dig_reg     <= '0;
      frac_reg    <= '0;
      started_reg <= 1'b0;
    end else if (fire) begin
      unique case (state_reg)
        S_IDLE: begin
          if (start_att || start_sns) begin
            state_reg   <= S_HDR;
            inst_reg    <= SEL_GYRO;
            hdr_idx_reg <= '0;
          end
        end
        S_HDR: begin
          if (hdr_idx_reg == 3'(HDR_LEN - 1)) begin
            state_reg <= S_COMMA;
            fld_reg   <= '0;
          end else begin
            hdr_idx_reg <= hdr_idx_reg + 1'b1;
          end
        end
        S_COMMA: begin
          // A comma also precedes the asterisk.
          if (last_field) begin
            state_reg <= S_STAR;
          end else begin
            mag_reg     <= fld_abs;
            pos_reg     <= fld_digits - 1'b1;
            frac_reg    <= fld_frac;
            dig_reg     <= '0;
            started_reg <= 1'b0;
            state_reg   <= fld_value[MAG_W] ? S_SIGN : S_DIV;
          end
        end
        S_SIGN: state_reg <= S_DIV;
        S_DIV: begin
          // Count how often this power of ten fits the remainder.
          if (mag_reg >= POW10[pos_reg]) begin
            mag_reg <= mag_reg - POW10[pos_reg];
            dig_reg <= dig_reg + 1'b1;
          end else begin
            state_reg <= S_DIGIT;
          end
        end
        S_DIGIT: begin
          started_reg <= show_digit;
          dig_reg     <= '0;
          if (pos_reg == frac_reg && frac_reg != 4'h0) begin
            state_reg <= S_POINT;
          end else if (pos_reg == 4'h0) begin
            fld_reg   <= fld_reg + 1'b1;
            state_reg <= S_COMMA;
          end else begin
            pos_reg   <= pos_reg - 1'b1;
            state_reg <= S_DIV;
          end
        end
        S_POINT: begin
          pos_reg   <= pos_reg - 1'b1;
          state_reg <= S_DIV;
        end
        S_STAR: state_reg <= S_CKH;
        S_CKH:  state_reg <= S_CKL;
        S_CKL:  state_reg <= S_CR;
        S_CR:   state_reg <= S_LF;
        S_LF: begin
          if (is_sns_reg && inst_reg != SEL_MAG) begin
            inst_reg    <= inst_reg + 1'b1;
            hdr_idx_reg <= '0;
            state_reg   <= S_HDR;
          end else begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Output buffer; a full FIFO stalls the sequencer.
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) out_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_byte),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

endmodule // sentence_framer

// [sentence_framer_checker.sv]
// Port-level assertions for the sentence framer.
module sentence_framer_checker import framer_pkg::*; (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst,
  // Request handshakes.
  input wire logic       att_valid,
  input wire logic       att_ready,
  input wire logic       sns_valid,
  input wire logic       sns_ready,
  // Output byte stream.
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic [7:0] out_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic       take;      // A byte leaves the framer this cycle.
  logic [7:0] last_reg;  // Last byte taken; LF as if a line just ended.
  assign take = out_valid && out_ready;
  // Tracks the previous taken byte to check what may follow it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) last_reg <= CHR_LF;
    else if (take) last_reg <= out_data;
  end
  property p_att_take;
    att_ready |-> att_valid ##1 !att_ready;
  endproperty
  a_att_take: assert property (p_att_take)
    else $error("Attitude ready without request or held on.");
  property p_sns_yield;
    sns_ready |-> sns_valid && !att_valid;
  endproperty
  a_sns_yield: assert property (p_sns_yield)
    else $error("Sensor ready while attitude waits.");
  property p_busy;
    (att_ready || sns_ready) |=> (!att_ready && !sns_ready)[*8];
  endproperty
  a_busy: assert property (p_busy)
    else $error("New request taken during a sentence.");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Byte changed or dropped while stalled.");
  property p_answer;
    att_ready && !out_valid |-> ##[1:2] out_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("No byte after an attitude request.");
  property p_dollar;
    take && last_reg == CHR_LF |-> out_data == ATT_HDR[0];
  endproperty
  a_dollar: assert property (p_dollar)
    else $error("Line does not open with the dollar sign.");
  property p_hex;
    take && last_reg == CHR_STAR |->
      out_data inside {[8'h30:8'h39], [8'h41:8'h46]};
  endproperty
  a_hex: assert property (p_hex)
    else $error("Checksum digit is not uppercase hex.");
  property p_lf;
    take && last_reg == CHR_CR |-> out_data == CHR_LF;
  endproperty
  a_lf: assert property (p_lf)
    else $error("Carriage return not followed by line feed.");
endmodule // sentence_framer_checker

// [test_sentence_framer.sv]
// Self-checking bench for the sentence framer and its host.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_sentence_framer import framer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS_DIV = 4;      // Short millisecond for simulation.
  localparam int LIMIT  = 40000;  // Cycle ceiling of the whole run.
  logic clk, rst, att_valid, att_ready, sns_valid, sns_ready;
  logic out_valid, out_ready, gps_present, gps_second_pulse, hold, slow;
  logic [7:0]                out_data;
  logic [UTC_W-1:0]          gps_utc_second;
  logic signed [ANGLE_W-1:0] gps_heading;
  attitude_type              att_data;
  raw_sensor_type            sns_data;
  longint                    av[4];  // Roll, pitch, yaw, heading.
  longint                    sv[9];  // Gyro, accel, mag triples.
  int num_errors, n_tests, cyc;
  sentence_framer #(.MS_DIV(MS_DIV), .FIFO_DEPTH(OUT_DEPTH))
    sentence_framer_inst (.clk(clk), .rst(rst), .att_valid(att_valid),
    .att_ready(att_ready), .att_data(att_data), .gps_heading(gps_heading),
    .sns_valid(sns_valid), .sns_ready(sns_ready), .sns_data(sns_data),
    .gps_present(gps_present), .gps_second_pulse(gps_second_pulse),
    .gps_utc_second(gps_utc_second), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  host_sink host_sink_inst (.clk(clk), .rst(rst), .hold(hold), .slow(slow),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // Cuts a hang short and reports it as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Header token text built from the package bytes.
  function automatic string hdr(bit sns);
    string s = "";
    for (int i = 0; i < HDR_LEN; i++)
      s = {s, string'(sns ? SNS_HDR[i] : ATT_HDR[i])};
    return s;
  endfunction
  // Signed fixed point with f decimals, clamped to d digits.
  function automatic string fx(longint v, int f, int d);
    longint m, p, c;
    string s;
    m = v < 0 ? -v : v;
    p = 1;
    c = 1;
    repeat (f) p *= 10;
    repeat (d) c *= 10;
    if (m > c - 1) m = c - 1;
    s = $sformatf("%0d", m % p);
    while (s.len() < f) s = {"0", s};
    return {v < 0 ? "-" : "", $sformatf("%0d.", m / p), s};
  endfunction
  // Uppercase hex character of one nibble.
  function automatic logic [7:0] hx(logic [3:0] n);
    return n < 10 ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic pop(output logic [7:0] b);
    wait (host_sink_inst.rx_q.size() != 0);
    b = host_sink_inst.rx_q.pop_front();
  endtask
  // Compares one line; T marks the time stamp, s its whole seconds.
  task automatic check_line(input string e, input int s, output string t);
    logic [7:0] b, x;
    int n;
    x = 8'h00;
    t = "";
    for (int i = 0; i < e.len(); i++) begin
      if (e[i] == "T") begin
        n = 0;
        do begin
          pop(b);
          x ^= b;
          t = {t, string'(b)};
          n++;
        end while (b !== CHR_POINT);
        repeat (3) begin
          pop(b);
          x ^= b;
          t = {t, string'(b)};
          `CHK(b inside {[8'h30:8'h39]}, 1'b1)
        end
        `CHK(n inside {[2:11]}, 1'b1)
        if (s >= 0) `CHK(t.atoi(), s)
      end else begin
        pop(b);
        `CHK(b, e[i])
        if (i > 0 && b !== CHR_STAR) x ^= b;
      end
    end
    pop(b);
    `CHK(b, hx(x[7:4]))
    pop(b);
    `CHK(b, hx(x[3:0]))
    pop(b);
    `CHK(b, CHR_CR)
    pop(b);
    `CHK(b, CHR_LF)
  endtask
  // Offers the requests together, then checks every line that results.
  task automatic t_mix(bit a, bit b, int s, string name);
    string e, t, t0;
    raw_sensor_type r;
    for (int k = 0; k < 9; k++) r[(8-k)*AXIS_W +: AXIS_W] = AXIS_W'(sv[k]);
    @(posedge clk);
    att_data <= {ANGLE_W'(av[0]), ANGLE_W'(av[1]), ANGLE_W'(av[2])};
    gps_heading <= ANGLE_W'(av[3]);
    sns_data <= r;
    att_valid <= a;
    sns_valid <= b;
    do begin
      @(posedge clk);
      if (att_ready === 1'b1) att_valid <= 1'b0;
      if (sns_ready === 1'b1) sns_valid <= 1'b0;
    end while (att_valid || sns_valid);
    if (a) begin
      e = {hdr(0), ",T"};
      for (int k = 0; k < 4; k++) e = {e, ",", fx(av[k], 2, 7)};
      check_line({e, ",*"}, s, t);
    end
    for (int j = 0; b && j < 3; j++) begin
      e = {hdr(1), $sformatf(",%0d,T", j)};
      for (int k = 0; k < 3; k++)
        e = {e, ",", fx(sv[3*j+k], j ? 4 : 2, 11)};
      check_line({e, ",*"}, -1, t);
      if (j == 0) t0 = t;
      `CHK(t == t0, 1'b1)
    end
    $display("%s done", name);
  endtask
  task automatic t_uptime();
    av = '{64'h07F0, -64'h0005, 64'h0000, -64'h464F};
    t_mix(1'b1, 1'b0, 0, "uptime attitude");
  endtask
  task automatic t_slow_sensor();
    sv = '{-64'hAFE2, 64'h0000, 64'h0001, -64'h2703, 64'h2710, 64'h000C,
           64'h1388, -64'h0001, 64'h17_4876_E800};
    slow <= 1'b1;
    t_mix(1'b0, 1'b1, -1, "slow sensor");
    slow <= 1'b0;
  endtask
  // Host stalls long enough for the FIFO to fill; attitude goes first.
  task automatic t_stall_both();
    av = '{64'hBC_614E, 64'h0001, -64'h0064, 64'h0000};
    hold <= 1'b1;
    fork
      begin
        repeat (300) @(posedge clk);
        `CHK(out_valid, 1'b1)
        hold <= 1'b0;
      end
    join_none
    t_mix(1'b1, 1'b1, -1, "stalled pair");
  endtask
  task automatic t_gps_time();
    gps_present <= 1'b1;
    gps_utc_second <= 17'h0_3039;
    gps_second_pulse <= 1'b1;
    @(posedge clk);
    gps_second_pulse <= 1'b0;
    t_mix(1'b1, 1'b1, 12345, "gps time");
  endtask
  // Main sequence: reset, scenarios, verdict.
  initial begin
    rst = 1'b1;
    {att_valid, sns_valid, gps_present, gps_second_pulse, hold, slow} = '0;
    {att_data, gps_heading, sns_data, gps_utc_second} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_uptime();
    t_slow_sensor();
    t_stall_both();
    t_gps_time();
    stop_test();
  end
endmodule // test_sentence_framer
bind sentence_framer sentence_framer_checker sentence_framer_checker_inst (
  .clk(clk), .rst(rst), .att_valid(att_valid), .att_ready(att_ready),
  .sns_valid(sns_valid), .sns_ready(sns_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data));
